// [tac_trace_address_compression.sv]
// module: address history, return stack and timestamp delta compression
//
// Contract
// RQ1: history holds the last three emitted addresses
// RQ2: target, source, implying Q packets push history
// RQ3: exception packet pushes preferred return address
// RQ4: unknown-address failure or reset pushes zero
// RQ5: target/source use exact match, else newest entry
// RQ6: exception/Q use exact match, else newest entry
// RQ7: trace info zeroes every history entry
// RQ8: return stack depth fixed, within zero to fifteen
// RQ9: enabled taken traced link branch pushes return
// RQ10: push shifts entries down, new at top
// RQ11: push when full drops oldest entry
// RQ12: initially taken link branch always pushes
// RQ13: initially not-taken link branch never pushes
// RQ14: no push for Q-implied or broadcast-region
// RQ15: taken traced indirect matching top pops
// RQ16: pop drops target and shifts entries up
// RQ17: Q-implied indirect never pops
// RQ18: mispredicted indirect emits correction, no pop
// RQ19: push evaluated before pop on same instruction
// RQ20: clear on info, trace on, broadcast entry
// RQ21: unsynced after info blocks pushes until both emitted
// RQ22: timestamp delta, reference zeroed on trace info
`timescale 1ns/100ps
module tac_trace_address_compression (
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              pkt_valid_i,
  input  wire tac_pkg::tac_pkt_t                 pkt_kind_i,
  input  wire logic [tac_pkg::ADDR_W-1:0]        pkt_addr_i,
  input  wire logic [tac_pkg::ISA_W-1:0]         pkt_isa_i,
  input  wire logic                              ctx_emit_i,
  input  wire logic                              waypoint_i,
  input  wire logic                              return_stack_enable_setting_i,
  input  wire logic                              bl_valid_i,
  input  wire logic                              bl_first_atom_e_i,
  input  wire logic                              bl_q_implied_i,
  input  wire logic [tac_pkg::ADDR_W-1:0]        bl_addr_i,
  input  wire logic [tac_pkg::SIZE_W-1:0]        bl_size_i,
  input  wire logic [tac_pkg::ISA_W-1:0]         bl_isa_i,
  input  wire logic                              bbr_region_i,
  input  wire logic                              ind_valid_i,
  input  wire logic                              ind_final_e_i,
  input  wire logic                              ind_mispredict_i,
  input  wire logic                              ind_q_implied_i,
  input  wire logic [tac_pkg::ADDR_W-1:0]        ind_addr_i,
  input  wire logic [tac_pkg::ISA_W-1:0]         ind_isa_i,
  input  wire logic                              ts_valid_i,
  input  wire logic [tac_pkg::TS_W-1:0]          ts_value_i,
  output logic                                   pkt_valid_o,
  output tac_pkg::tac_pkt_t                      pkt_kind_o,
  output logic                                   pkt_exact_o,
  output logic [tac_pkg::HIST_IDX_W-1:0]         pkt_exact_idx_o,
  output logic [tac_pkg::ADDR_W-1:0]             pkt_ref_addr_o,
  output logic [tac_pkg::ISA_W-1:0]              pkt_ref_isa_o,
  output logic [tac_pkg::ADDR_W-1:0]             pkt_addr_o,
  output logic [tac_pkg::ISA_W-1:0]              pkt_isa_o,
  output logic                                   tgt_valid_o,
  output logic [tac_pkg::ADDR_W-1:0]             tgt_addr_o,
  output logic [tac_pkg::ISA_W-1:0]              tgt_isa_o,
  output logic                                   tgt_dropped_o,
  output logic [tac_pkg::RS_CNT_W-1:0]           rs_depth_o,
  output logic                                   sync_hold_o,
  output logic                                   ts_valid_o,
  output logic [tac_pkg::TS_W-1:0]               ts_mask_o,
  output logic [tac_pkg::TS_W-1:0]               ts_value_o
);
  import tac_pkg::*;

  // ---------------------------------------------------------------
  // address history
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0]     hist_addr_r [HIST_DEPTH];
  logic [ISA_W-1:0]      hist_isa_r  [HIST_DEPTH];
  logic                  is_info;
  logic                  is_addr_pkt;
  logic                  is_unk_pkt;
  logic                  hist_push;
  logic [ADDR_W-1:0]     push_addr;
  logic [ISA_W-1:0]      push_isa;
  logic                  hit;
  logic [HIST_IDX_W-1:0] hit_idx;

  assign is_info     = pkt_valid_i && (pkt_kind_i == TAC_PKT_TRACE_INFO);
  assign is_addr_pkt = pkt_valid_i && (pkt_kind_i == TAC_PKT_TARGET ||
                       pkt_kind_i == TAC_PKT_SOURCE || pkt_kind_i == TAC_PKT_EXCEPTION ||
                       pkt_kind_i == TAC_PKT_Q_TARGET);
  assign is_unk_pkt  = pkt_valid_i && (pkt_kind_i == TAC_PKT_TXFAIL_UNK ||
                       pkt_kind_i == TAC_PKT_RESET_UNK);
  assign hist_push   = is_addr_pkt || is_unk_pkt;
  // unknown addresses are recorded as zero in the base set
  assign push_addr   = is_unk_pkt ? ADDR_ZERO : pkt_addr_i;                 // RQ4
  assign push_isa    = is_unk_pkt ? BASE_INSTRUCTION_SET_CODE : pkt_isa_i;  // RQ4

  // newest match wins, so the lowest index is reported
  always_comb begin
    hit     = 1'b0;
    hit_idx = HIST_IDX_ZERO;
    for (int i = HIST_DEPTH - 1; i >= 0; i--) begin
      if (hist_addr_r[i] == pkt_addr_i && hist_isa_r[i] == pkt_isa_i) begin
        hit     = 1'b1;
        hit_idx = HIST_IDX_W'(i);
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_addr_r[i] <= ADDR_ZERO;
        hist_isa_r[i]  <= BASE_INSTRUCTION_SET_CODE;
      end
    end else if (is_info) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_addr_r[i] <= ADDR_ZERO;                                        // RQ7
        hist_isa_r[i]  <= BASE_INSTRUCTION_SET_CODE;                        // RQ7
      end
    end else if (hist_push) begin
      // exception packets carry the preferred return address in pkt_addr_i
      for (int i = HIST_DEPTH - 1; i > 0; i--) begin
        hist_addr_r[i] <= hist_addr_r[i-1];                                 // RQ1
        hist_isa_r[i]  <= hist_isa_r[i-1];
      end
      hist_addr_r[0] <= push_addr;                                          // RQ2 RQ3
      hist_isa_r[0]  <= push_isa;
    end
  end

  // ---------------------------------------------------------------
  // packet form selection
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pkt_valid_o     <= 1'b0;
      pkt_kind_o      <= TAC_PKT_TARGET;
      pkt_exact_o     <= 1'b0;
      pkt_exact_idx_o <= HIST_IDX_ZERO;
      pkt_ref_addr_o  <= ADDR_ZERO;
      pkt_ref_isa_o   <= BASE_INSTRUCTION_SET_CODE;
      pkt_addr_o      <= ADDR_ZERO;
      pkt_isa_o       <= BASE_INSTRUCTION_SET_CODE;
    end else begin
      pkt_valid_o     <= pkt_valid_i;
      pkt_kind_o      <= pkt_kind_i;
      pkt_exact_o     <= is_addr_pkt && hit;                                // RQ5 RQ6
      pkt_exact_idx_o <= hit_idx;
      pkt_ref_addr_o  <= hist_addr_r[0];                                    // RQ5 RQ6
      pkt_ref_isa_o   <= hist_isa_r[0];
      pkt_addr_o      <= push_addr;
      pkt_isa_o       <= push_isa;
    end
  end

  // ---------------------------------------------------------------
  // synchronisation after trace info
  // ---------------------------------------------------------------
  tac_sync_t sync_r;
  logic      tgt_seen_r;
  logic      ctx_seen_r;
  logic      tgt_now;
  logic      both_seen;

  assign tgt_now   = pkt_valid_i && (pkt_kind_i == TAC_PKT_TARGET);
  assign both_seen = (tgt_seen_r || tgt_now) && (ctx_seen_r || ctx_emit_i);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgt_seen_r <= 1'b0;
      ctx_seen_r <= 1'b0;
    end else if (is_info) begin
      tgt_seen_r <= 1'b0;
      ctx_seen_r <= 1'b0;
    end else begin
      tgt_seen_r <= tgt_seen_r || tgt_now;
      ctx_seen_r <= ctx_seen_r || ctx_emit_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_r <= TAC_SYNC_OK;
    end else if (is_info) begin
      sync_r <= TAC_SYNC_WAIT;
    end else begin
      unique case (sync_r)
        TAC_SYNC_OK: sync_r <= TAC_SYNC_OK;
        TAC_SYNC_WAIT: begin
          if (both_seen) begin
            sync_r <= TAC_SYNC_OK;
          end else if (waypoint_i) begin
            sync_r <= TAC_SYNC_HOLD;                                        // RQ21
          end
        end
        TAC_SYNC_HOLD: begin
          if (both_seen) begin
            sync_r <= TAC_SYNC_OK;                                          // RQ21
          end
        end
        default: sync_r <= TAC_SYNC_OK;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // return stack
  // ---------------------------------------------------------------
  // depth is fixed in the package; a lost entry only costs bandwidth
  logic [ADDR_W-1:0]   rs_addr_r [RS_DEPTH];                               // RQ8
  logic [ISA_W-1:0]    rs_isa_r  [RS_DEPTH];
  logic [RS_CNT_W-1:0] rs_cnt_r;
  logic                bbr_prev_r;
  logic                rs_clear;
  logic                rs_push;
  logic                rs_pop;
  logic [ADDR_W-1:0]   ret_addr;
  logic [ADDR_W-1:0]   top_addr;
  logic [ISA_W-1:0]    top_isa;
  logic [RS_CNT_W-1:0] cnt_after_push;

  assign ret_addr = bl_addr_i + ADDR_W'(bl_size_i);                        // RQ9
  assign rs_clear = is_info || (pkt_valid_i && pkt_kind_i == TAC_PKT_TRACE_ON) ||
                    (bbr_region_i && !bbr_prev_r);                          // RQ20
  // only the first atom matters; later corrections are not seen here
  assign rs_push  = return_stack_enable_setting_i && bl_valid_i &&
                    bl_first_atom_e_i &&                                    // RQ12 RQ13
                    !bl_q_implied_i && !bbr_region_i &&                     // RQ14
                    (sync_r != TAC_SYNC_HOLD) && !rs_clear;                 // RQ21
  // the pop compares against the stack as it stands after any push
  assign top_addr = rs_push ? ret_addr : rs_addr_r[0];                     // RQ19
  assign top_isa  = rs_push ? bl_isa_i : rs_isa_r[0];
  assign cnt_after_push = (rs_push && rs_cnt_r != RS_FULL) ? rs_cnt_r + RS_ONE : rs_cnt_r;
  assign rs_pop   = ind_valid_i && ind_final_e_i && !ind_mispredict_i &&    // RQ15 RQ18
                    !ind_q_implied_i && !rs_clear &&                        // RQ17
                    cnt_after_push != RS_EMPTY &&
                    ind_addr_i == top_addr && ind_isa_i == top_isa;         // RQ15

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bbr_prev_r <= 1'b0;
    end else begin
      bbr_prev_r <= bbr_region_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rs_cnt_r <= RS_EMPTY;
    end else if (rs_clear) begin
      rs_cnt_r <= RS_EMPTY;                                                 // RQ20
    end else begin
      rs_cnt_r <= rs_pop ? cnt_after_push - RS_ONE : cnt_after_push;        // RQ11 RQ16
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < RS_DEPTH; i++) begin
        rs_addr_r[i] <= ADDR_ZERO;
        rs_isa_r[i]  <= BASE_INSTRUCTION_SET_CODE;
      end
    end else if (rs_push && !rs_pop) begin
      for (int i = RS_DEPTH - 1; i > 0; i--) begin
        rs_addr_r[i] <= rs_addr_r[i-1];                                     // RQ10 RQ11
        rs_isa_r[i]  <= rs_isa_r[i-1];
      end
      rs_addr_r[0] <= ret_addr;                                             // RQ9 RQ10
      rs_isa_r[0]  <= bl_isa_i;
    end else if (rs_pop && !rs_push) begin
      for (int i = 0; i < RS_DEPTH - 1; i++) begin
        rs_addr_r[i] <= rs_addr_r[i+1];                                     // RQ16
        rs_isa_r[i]  <= rs_isa_r[i+1];
      end
    end
  end

  // ---------------------------------------------------------------
  // target element output
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgt_valid_o   <= 1'b0;
      tgt_dropped_o <= 1'b0;
      tgt_addr_o    <= ADDR_ZERO;
      tgt_isa_o     <= BASE_INSTRUCTION_SET_CODE;
    end else begin
      // a mispredict delivers the corrected address here
      tgt_valid_o   <= ind_valid_i && ind_final_e_i && !rs_pop;             // RQ16 RQ18
      tgt_dropped_o <= rs_pop;                                              // RQ16
      tgt_addr_o    <= ind_addr_i;
      tgt_isa_o     <= ind_isa_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rs_depth_o  <= RS_EMPTY;
      sync_hold_o <= 1'b0;
    end else begin
      rs_depth_o  <= rs_clear ? RS_EMPTY : (rs_pop ? cnt_after_push - RS_ONE : cnt_after_push);
      sync_hold_o <= (sync_r == TAC_SYNC_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // timestamp delta
  // ---------------------------------------------------------------
  logic [TS_W-1:0] ts_last_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ts_last_r <= TS_ZERO;
    end else if (is_info) begin
      ts_last_r <= TS_ZERO;                                                 // RQ22
    end else if (ts_valid_i) begin
      ts_last_r <= ts_value_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ts_valid_o <= 1'b0;
      ts_mask_o  <= TS_ZERO;
      ts_value_o <= TS_ZERO;
    end else begin
      ts_valid_o <= ts_valid_i;
      ts_mask_o  <= ts_value_i ^ (is_info ? TS_ZERO : ts_last_r);           // RQ22
      ts_value_o <= ts_value_i;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_hist_push;
    is_addr_pkt && !is_info |=> hist_addr_r[0] == $past(pkt_addr_i) &&
      hist_addr_r[1] == $past(hist_addr_r[0]) && hist_addr_r[2] == $past(hist_addr_r[1]);
  endproperty
  a_hist_push: assert property (p_hist_push) else $error("history push wrong"); // RQ1 RQ2

  property p_exc_push;
    pkt_valid_i && pkt_kind_i == TAC_PKT_EXCEPTION |=>
      hist_addr_r[0] == $past(pkt_addr_i) && hist_isa_r[0] == $past(pkt_isa_i);
  endproperty
  a_exc_push: assert property (p_exc_push) else $error("exception push wrong"); // RQ3

  property p_unk_push;
    is_unk_pkt |=> hist_addr_r[0] == ADDR_ZERO && hist_isa_r[0] == BASE_INSTRUCTION_SET_CODE;
  endproperty
  a_unk_push: assert property (p_unk_push) else $error("unknown push not zero"); // RQ4

  property p_exact;
    is_addr_pkt && hist_addr_r[1] == pkt_addr_i && hist_isa_r[1] == pkt_isa_i &&
      !(hist_addr_r[0] == pkt_addr_i && hist_isa_r[0] == pkt_isa_i)
      |=> pkt_exact_o && pkt_exact_idx_o == 2'h1;
  endproperty
  a_exact: assert property (p_exact) else $error("exact match missed"); // RQ5 RQ6

  property p_relative;
    is_addr_pkt && !hit |=> !pkt_exact_o && pkt_ref_addr_o == $past(hist_addr_r[0]);
  endproperty
  a_relative: assert property (p_relative) else $error("relative form wrong"); // RQ5 RQ6

  property p_info_zero;
    is_info |=> hist_addr_r[0] == ADDR_ZERO && hist_addr_r[1] == ADDR_ZERO &&
      hist_addr_r[2] == ADDR_ZERO && rs_cnt_r == RS_EMPTY;
  endproperty
  a_info_zero: assert property (p_info_zero) else $error("info clear failed"); // RQ7 RQ20

  property p_full_push;
    rs_cnt_r == RS_FULL && rs_push && !rs_pop |=> rs_cnt_r == RS_FULL &&
      rs_addr_r[3] == $past(rs_addr_r[2]);
  endproperty
  a_full_push: assert property (p_full_push) else $error("full push wrong"); // RQ10 RQ11

  property p_no_push_n;
    bl_valid_i && !bl_first_atom_e_i && !ind_valid_i |=> rs_cnt_r <= $past(rs_cnt_r);
  endproperty
  a_no_push_n: assert property (p_no_push_n) else $error("push on N atom"); // RQ13

  property p_pop;
    rs_pop && !rs_push |=> tgt_dropped_o && !tgt_valid_o && rs_cnt_r == $past(rs_cnt_r) - RS_ONE;
  endproperty
  a_pop: assert property (p_pop) else $error("pop effect wrong"); // RQ16

  property p_mispredict;
    ind_valid_i && ind_final_e_i && ind_mispredict_i |=> tgt_valid_o && !tgt_dropped_o;
  endproperty
  a_mispredict: assert property (p_mispredict) else $error("mispredict popped"); // RQ18

  property p_ts_first;
    (is_info || ts_last_r == TS_ZERO) && ts_valid_i |=> ts_mask_o == $past(ts_value_i);
  endproperty
  a_ts_first: assert property (p_ts_first) else $error("timestamp not full"); // RQ22

  c_exact:  cover property (is_addr_pkt && hit);
  c_pop:    cover property (rs_pop);
  c_both:   cover property (rs_push && rs_pop);
  c_hold:   cover property (sync_r == TAC_SYNC_HOLD ##[1:20] sync_r == TAC_SYNC_OK);

endmodule // tac_trace_address_compression

// [tac_pkg.sv]
// package: constants and types of the trace address compression block
package tac_pkg;

  // ---------------------------------------------------------------
  // widths and depths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 64;
  localparam int unsigned ISA_W      = 2;
  localparam int unsigned SIZE_W     = 3;
  localparam int unsigned TS_W       = 64;
  localparam int unsigned HIST_DEPTH = 3;
  localparam int unsigned HIST_IDX_W = 2;
  localparam int unsigned RS_DEPTH   = 4;
  localparam int unsigned RS_CNT_W   = 3;

  // ---------------------------------------------------------------
  // reset and cleared values, return stack count limits
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0]     ADDR_ZERO                 = 64'h0;
  localparam logic [ISA_W-1:0]      BASE_INSTRUCTION_SET_CODE = 2'h0;
  localparam logic [TS_W-1:0]       TS_ZERO                   = 64'h0;
  localparam logic [RS_CNT_W-1:0]   RS_EMPTY                  = 3'h0;
  localparam logic [RS_CNT_W-1:0]   RS_FULL                   = 3'h4;
  localparam logic [RS_CNT_W-1:0]   RS_ONE                    = 3'h1;
  localparam logic [HIST_IDX_W-1:0] HIST_IDX_ZERO             = 2'h0;

  // ---------------------------------------------------------------
  // packet kinds handed over by the packet generator
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TAC_PKT_TARGET     = 3'h0,
    TAC_PKT_SOURCE     = 3'h1,
    TAC_PKT_EXCEPTION  = 3'h2,
    TAC_PKT_Q_TARGET   = 3'h3,
    TAC_PKT_TXFAIL_UNK = 3'h4,
    TAC_PKT_RESET_UNK  = 3'h5,
    TAC_PKT_TRACE_INFO = 3'h6,
    TAC_PKT_TRACE_ON   = 3'h7
  } tac_pkt_t;

  // ---------------------------------------------------------------
  // return stack synchronisation after trace info
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TAC_SYNC_OK   = 2'h0,
    TAC_SYNC_WAIT = 2'h1,
    TAC_SYNC_HOLD = 2'h3
  } tac_sync_t;

endpackage

// [tac_core_model.sv]
// core model: reports link branches and indirect targets to the compression block
`timescale 1ns/100ps
module tac_core_model (
  output logic                       blv_o,
  output logic                       ble_o,
  output logic                       blq_o,
  output logic [tac_pkg::ADDR_W-1:0] bla_o,
  output logic [tac_pkg::SIZE_W-1:0] bls_o,
  output logic [tac_pkg::ISA_W-1:0]  bli_o,
  output logic                       inv_o,
  output logic                       ine_o,
  output logic                       inm_o,
  output logic                       inq_o,
  output logic [tac_pkg::ADDR_W-1:0] ina_o,
  output logic [tac_pkg::ISA_W-1:0]  ini_o
);
  import tac_pkg::*;
  // ----------------------------------------------------------------
  // reporting tasks, called just after a falling edge
  // ----------------------------------------------------------------
  task automatic link(input logic [ADDR_W-1:0] a, input logic e, input logic q);
    blv_o = 1'b1;
    ble_o = e;
    blq_o = q;
    bla_o = a;
  endtask
  task automatic ret(input logic [ADDR_W-1:0] a, input logic f, input logic m, input logic q);
    inv_o = 1'b1;
    ine_o = f;
    inm_o = m;
    inq_o = q;
    ina_o = a;
  endtask
  // released addresses flip so a stale value never passes for a report
  task automatic idle();
    blv_o = 1'b0;
    inv_o = 1'b0;
    bla_o = ~bla_o;
    ina_o = ~ina_o;
  endtask
  initial begin
    blv_o = 1'b0;
    ble_o = 1'b0;
    blq_o = 1'b0;
    bla_o = 64'h0;
    bls_o = 3'h4;
    bli_o = 2'h1;
    inv_o = 1'b0;
    ine_o = 1'b0;
    inm_o = 1'b0;
    inq_o = 1'b0;
    ina_o = 64'h0;
    ini_o = 2'h1;
  end
endmodule // tac_core_model

// [test_trace_address_compression.sv]
// testbench: history, return stack and timestamp compression checks
`timescale 1ns/100ps
module test_trace_address_compression;
  import tac_pkg::*;
  typedef struct packed {
    tac_pkt_t k; logic [63:0] a; logic [1:0] s; logic e; logic [1:0] x; logic [63:0] r;
  } tac_row_t;
  logic clk, rst, pv, ctx, wp, en, bbr, tsv, blv, ble, blq, inv, ine, inm, inq;
  logic ov, oe, tv, td, sh, otv;
  tac_pkt_t pk, ok;
  logic [63:0] pa, bla, ina, tsval, ora, oa, tmask, ta;
  logic [2:0] bls, dep;
  logic [1:0] pi, bli, ini, ox;
  int error_cnt = 0;
  int cmp_count = 0;
  tac_row_t rows [12];
  tac_core_model core_i (.blv_o(blv), .ble_o(ble), .blq_o(blq), .bla_o(bla), .bls_o(bls),
    .bli_o(bli), .inv_o(inv), .ine_o(ine), .inm_o(inm), .inq_o(inq), .ina_o(ina), .ini_o(ini));
  tac_trace_address_compression tac_trace_address_compression_i (.sys_clk_i(clk),
    .rst_i(rst), .pkt_valid_i(pv), .pkt_kind_i(pk), .pkt_addr_i(pa), .pkt_isa_i(pi),
    .ctx_emit_i(ctx), .waypoint_i(wp), .return_stack_enable_setting_i(en),
    .bl_valid_i(blv), .bl_first_atom_e_i(ble), .bl_q_implied_i(blq), .bl_addr_i(bla),
    .bl_size_i(bls), .bl_isa_i(bli), .bbr_region_i(bbr), .ind_valid_i(inv),
    .ind_final_e_i(ine), .ind_mispredict_i(inm), .ind_q_implied_i(inq), .ind_addr_i(ina),
    .ind_isa_i(ini), .ts_valid_i(tsv), .ts_value_i(tsval), .pkt_valid_o(ov),
    .pkt_kind_o(ok), .pkt_exact_o(oe), .pkt_exact_idx_o(ox), .pkt_ref_addr_o(ora),
    .pkt_ref_isa_o(), .pkt_addr_o(oa), .pkt_isa_o(), .tgt_valid_o(tv), .tgt_addr_o(ta),
    .tgt_isa_o(), .tgt_dropped_o(td), .rs_depth_o(dep), .sync_hold_o(sh),
    .ts_valid_o(otv), .ts_mask_o(tmask), .ts_value_o());
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // wide enough for the packed kind, valid and address groups compared at once
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // every stimulus is followed by a release edge, so no pulse is set twice at once
  task automatic cyc();
    @(negedge clk);
    core_i.idle();
    pv = 1'b0;
    ctx = 1'b0;
    wp = 1'b0;
    tsv = 1'b0;
    pa = ~pa;
  endtask
  task automatic pkt(input tac_pkt_t k, input logic [63:0] a, input logic [1:0] s);
    @(negedge clk);
    pv = 1'b1;
    pk = k;
    pa = a;
    pi = s;
  endtask
  task automatic push(input logic [63:0] a, input logic e, input logic q, input logic [2:0] d);
    @(negedge clk);
    core_i.link(a, e, q);
    cyc();
    chk(dep, d);
  endtask
  task automatic pop(input logic [63:0] a, input logic f, input logic m, input logic q,
                     input logic drop);
    @(negedge clk);
    core_i.ret(a, f, m, q);
    cyc();
    chk(td, drop);
    if (!q) chk(tv, f & ~drop);
    if (f & ~drop & ~q) chk(ta, a);
  endtask
  task automatic tstamp(input logic [63:0] v, input logic [63:0] m);
    @(negedge clk);
    tsv = 1'b1;
    tsval = v;
    cyc();
    chk({otv, tmask}, {1'b1, m});
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50000;
    error_cnt++;
    final_report();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {pv, ctx, wp, en, bbr, tsv, pi} = '0;
    pk = TAC_PKT_TARGET;
    pa = 64'h0;
    tsval = 64'h0;
    rows = '{'{TAC_PKT_TARGET, 64'h100, 2'h1, 1'b0, 2'h0, 64'h0},
      '{TAC_PKT_SOURCE, 64'h200, 2'h1, 1'b0, 2'h0, 64'h100},
      '{TAC_PKT_EXCEPTION, 64'h300, 2'h2, 1'b0, 2'h0, 64'h200},
      '{TAC_PKT_Q_TARGET, 64'h100, 2'h1, 1'b1, 2'h2, 64'h300},
      '{TAC_PKT_TARGET, 64'h200, 2'h1, 1'b1, 2'h2, 64'h100},
      '{TAC_PKT_TXFAIL_UNK, 64'h5A5, 2'h3, 1'b0, 2'h0, 64'h200},
      '{TAC_PKT_TARGET, 64'h300, 2'h2, 1'b0, 2'h0, 64'h0},
      '{TAC_PKT_RESET_UNK, 64'h777, 2'h1, 1'b0, 2'h0, 64'h300},
      '{TAC_PKT_TARGET, 64'h0, 2'h0, 1'b1, 2'h0, 64'h0},
      '{TAC_PKT_TARGET, 64'h300, 2'h1, 1'b0, 2'h0, 64'h0},
      '{TAC_PKT_TRACE_INFO, 64'h0, 2'h0, 1'b0, 2'h0, 64'h300},
      '{TAC_PKT_SOURCE, 64'h300, 2'h1, 1'b0, 2'h0, 64'h0}};
    do_reset();
    chk({ov, dep, sh}, 5'h0);
    foreach (rows[i]) begin
      pkt(rows[i].k, rows[i].a, rows[i].s);
      cyc();
      chk({ov, ok, ora}, {1'b1, rows[i].k, rows[i].r});
      if (rows[i].k < TAC_PKT_TXFAIL_UNK) chk({oe, ox}, {rows[i].e, rows[i].x});
      if (rows[i].k < TAC_PKT_TRACE_INFO) chk(oa, rows[i].k > 3 ? 64'h0 : rows[i].a);
    end
    do_reset();
    en = 1'b1;
    tstamp(64'hF0, 64'hF0);
    tstamp(64'hF3, 64'h03);
    for (int i = 1; i < 6; i++) push(i * 16, 1'b1, 1'b0, i > 4 ? 3'h4 : 3'(i));
    for (int i = 5; i > 0; i--) pop(i * 16 + 4, 1'b1, 1'b0, 1'b0, i > 1);
    push(64'h40, 1'b0, 1'b0, 3'h0);
    push(64'h40, 1'b1, 1'b1, 3'h0);
    push(64'h2000, 1'b1, 1'b0, 3'h1);
    pop(64'h2004, 1'b1, 1'b1, 1'b0, 1'b0);
    pop(64'h2004, 1'b1, 1'b0, 1'b1, 1'b0);
    pop(64'h2004, 1'b0, 1'b0, 1'b0, 1'b0);
    pop(64'h2008, 1'b1, 1'b0, 1'b0, 1'b0);
    pop(64'h2004, 1'b1, 1'b0, 1'b0, 1'b1);
    @(negedge clk);
    core_i.link(64'h3000, 1'b1, 1'b0);
    core_i.ret(64'h3004, 1'b1, 1'b0, 1'b0);
    cyc();
    chk({td, dep}, 4'h8);
    push(64'h50, 1'b1, 1'b0, 3'h1);
    pkt(TAC_PKT_TRACE_ON, 64'h0, 2'h0);
    cyc();
    chk(dep, 3'h0);
    push(64'h50, 1'b1, 1'b0, 3'h1);
    @(negedge clk);
    bbr = 1'b1;
    @(negedge clk);
    chk(dep, 3'h0);
    push(64'h60, 1'b1, 1'b0, 3'h0);
    bbr = 1'b0;
    en = 1'b0;
    push(64'h60, 1'b1, 1'b0, 3'h0);
    en = 1'b1;
    pkt(TAC_PKT_TRACE_INFO, 64'h0, 2'h0);
    cyc();
    @(negedge clk);
    wp = 1'b1;
    cyc();
    @(negedge clk);
    chk(sh, 1'b1);
    push(64'h70, 1'b1, 1'b0, 3'h0);
    pkt(TAC_PKT_TARGET, 64'h80, 2'h1);
    ctx = 1'b1;
    cyc();
    @(negedge clk);
    chk(sh, 1'b0);
    push(64'h70, 1'b1, 1'b0, 3'h1);
    tstamp(64'hF3, 64'hF3);
    final_report();
  end
endmodule // test_trace_address_compression
